// *** hw/cibr_defines.svh ***
/*
 holds offsets, field positions, reset values and timing counts of the
 miscellaneous status register bank.
 assumes it is included by bare name from design and testbench files.
*/
`ifndef CIBR_DEFINES_SVH
`define CIBR_DEFINES_SVH

// register byte offsets
`define CIBR_OFS_IDENTITY     12'h050
`define CIBR_OFS_BYTE_ORDER   12'h064
`define CIBR_OFS_CONFIG       12'h074

// identity field positions
`define CIBR_ID_MSB           31
`define CIBR_ID_LSB           16
`define CIBR_REV_MSB          15
`define CIBR_REV_LSB          0

// arbitrary neutral identity and revision values
`define CIBR_CHIP_ID          16'h0a5c
`define CIBR_CHIP_REV         16'h0001

// byte order pattern and the value shown while in reset
`define CIBR_BYTE_PATTERN     32'h87654321
`define CIBR_RESET_PATTERN    32'hffffffff

// ready flag position in the configuration word
`define CIBR_READY_BIT        27

// settle time in ns before ready rises, and its cycle count at 4 ns
`define CIBR_SETTLE_NS        100
`define CIBR_CLK_NS           4
`define CIBR_SETTLE_CYCLES    ((`CIBR_SETTLE_NS + `CIBR_CLK_NS - 1) / `CIBR_CLK_NS)

`endif

// *** hw/cibr_pkg.sv ***
/*
 holds the types shared by the status register bank.
 assumes the defines header is compiled alongside.
*/
package cibr_pkg;

   // ready sequencer states
   typedef enum logic [1:0]
   {
      cibr_st_hold,
      cibr_st_settle,
      cibr_st_ready
   } cibr_state_type;

   // 32-bit register word
   typedef logic [31:0] cibr_word_type;

endpackage

// *** hw/cibr_rd_if.sv ***
/*
 holds the read path bundle between the bank and its byte lane steering.
 assumes one clock domain; carries a word and the lanes the host asks for.
*/
`timescale 1ns/1ns

interface cibr_rd_if;
   logic [31:0] word;      // word selected by the address decode
   logic [3:0]  lanes;     // byte lanes wanted by the host
   logic [31:0] steered;   // word with unwanted lanes at zero

   // bank side supplies the word, steering returns it
   modport bank
   (
      output word,
      output lanes,
      input  steered
   );

   // steering side
   modport steer
   (
      input  word,
      input  lanes,
      output steered
   );
endinterface

// *** hw/cibr_lane_steer.sv ***
/*
 holds the byte lane steering that lets the host read any subset of bytes.
 assumes lanes are valid in the same cycle as the word.
*/
`timescale 1ns/1ns

module cibr_lane_steer
(
   cibr_rd_if.steer rd
);

   genvar g;

   // each lane passes only if requested, so partial reads stand alone
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : lane
         assign rd.steered[g*8 +: 8] = rd.lanes[g] ? rd.word[g*8 +: 8] : 8'h00;
      end
   endgenerate

endmodule

// *** hw/cibr_status_regs.sv ***
/*
 holds the miscellaneous status register bank: identity word, byte order
 pattern and hardware configuration with the device ready flag.
 assumes a single-cycle host read port on sys_clk; pin-level inputs are
 synchronised here; the interrupt controller sits outside and takes a pulse.
*/
`timescale 1ns/1ns
`include "cibr_defines.svh"

module cibr_status_regs
(
   input  wire logic        sys_clk,        // 250 mhz system clock
   input  wire logic        srst,           // synchronous reset, active high
   input  wire logic        clk_en,         // freezes all state while low
   input  wire logic        dev_reset_pin,  // device-wide reset state, async level
   input  wire logic        power_saving,   // power saving state, async level
   input  wire logic        stable_pin,     // clocks and supplies stable, async level
   input  wire logic        rd_req,         // host read strobe, one cycle
   input  wire logic [11:0] rd_addr,        // host byte address
   input  wire logic [3:0]  rd_lanes,       // byte lanes wanted
   input  wire logic        wr_req,         // host write strobe, one cycle
   input  wire logic [11:0] wr_addr,        // host write byte address
   input  wire logic [31:0] wr_data,        // host write data, all ignored here
   output logic [31:0]      rd_data,        // read data, registered
   output logic             rd_ack,         // read answer, one cycle
   output logic             rd_hit,         // address belonged to this bank
   output logic             wr_ack,         // write answer, one cycle
   output logic             dev_ready,      // ready flag, registered
   output logic             pm_ready_bit,   // power control bit zero copy
   output logic             ready_int_set   // pulse that sets ready interrupt status
);

   // two-stage synchronisers for pin levels
   logic                    rst_meta_q;     // first stage, reset state
   logic                    rst_sync_q;     // second stage, reset state
   logic                    ps_meta_q;      // first stage, power saving
   logic                    ps_sync_q;      // second stage, power saving
   logic                    st_meta_q;      // first stage, stable
   logic                    st_sync_q;      // second stage, stable

   // ready sequencer
   cibr_pkg::cibr_state_type state_q;       // sequencer state
   cibr_pkg::cibr_state_type state_d;       // next sequencer state
   logic [7:0]              settle_q;       // settle cycle counter
   logic                    ready_q;        // device ready flag
   logic                    ready_d;        // next ready flag
   logic                    ready_prev_q;   // ready one cycle ago, edge detect
   logic                    int_pulse_q;    // registered interrupt set pulse

   // read path
   cibr_pkg::cibr_word_type sel_word;       // decoded word
   logic                    sel_hit;        // decode matched
   logic [31:0]             rd_data_q;      // read data register
   logic                    rd_ack_q;       // read answer register
   logic                    rd_hit_q;       // hit flag register
   logic                    wr_ack_q;       // write answer register
   logic                    block_rst;      // reset or power saving hold condition

   localparam logic [7:0] SETTLE_MAX = 8'(`CIBR_SETTLE_CYCLES - 1);

   cibr_rd_if rd_bus ();

   // synchronise the reset state pin
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= 1'b1;
      end
      else if (clk_en)
      begin
         rst_meta_q <= dev_reset_pin;
         rst_sync_q <= rst_meta_q;
      end
   end

   // synchronise the power saving pin
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ps_meta_q <= 1'b0;
         ps_sync_q <= 1'b0;
      end
      else if (clk_en)
      begin
         ps_meta_q <= power_saving;
         ps_sync_q <= ps_meta_q;
      end
   end

   // synchronise the stable pin
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st_meta_q <= 1'b0;
         st_sync_q <= 1'b0;
      end
      else if (clk_en)
      begin
         st_meta_q <= stable_pin;
         st_sync_q <= st_meta_q;
      end
   end

   // any reset or power saving state forces ready low
   assign block_rst = rst_sync_q | ps_sync_q;

   // sequencer next state: hold, settle a fixed time, then ready
   always_comb
   begin
      state_d = state_q;
      ready_d = 1'b0;
      case (state_q)
         cibr_pkg::cibr_st_hold:
         begin
            // wait out resets and for stable supplies
            if (!block_rst && st_sync_q)
            begin
               state_d = cibr_pkg::cibr_st_settle;
            end
         end
         cibr_pkg::cibr_st_settle:
         begin
            // count the settle time, abort on any reset
            if (block_rst || !st_sync_q)
            begin
               state_d = cibr_pkg::cibr_st_hold;
            end
            else if (settle_q == SETTLE_MAX)
            begin
               state_d = cibr_pkg::cibr_st_ready;
               ready_d = 1'b1;
            end
         end
         cibr_pkg::cibr_st_ready:
         begin
            // stay ready until a reset or power saving returns or stable drops
            if (block_rst || !st_sync_q)
            begin
               state_d = cibr_pkg::cibr_st_hold;
            end
            else
            begin
               ready_d = 1'b1;
            end
         end
         default:
         begin
            state_d = cibr_pkg::cibr_st_hold;
         end
      endcase
   end

   // sequencer state register
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_q <= cibr_pkg::cibr_st_hold;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
      end
   end

   // settle counter runs only in the settle state
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         settle_q <= 8'h00;
      end
      else if (clk_en)
      begin
         if (state_q == cibr_pkg::cibr_st_settle)
         begin
            settle_q <= settle_q + 8'h01;
         end
         else
         begin
            settle_q <= 8'h00;
         end
      end
   end

   // ready flag, low from every reset source
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ready_q <= 1'b0;
      end
      else if (clk_en)
      begin
         ready_q <= ready_d;
      end
   end

   // rising edge of ready raises the interrupt status set pulse
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ready_prev_q <= 1'b0;
         int_pulse_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         ready_prev_q <= ready_q;
         int_pulse_q  <= ready_q & ~ready_prev_q;
      end
   end

   // address decode of the three words
   always_comb
   begin
      sel_word = 32'h00000000;
      sel_hit  = 1'b1;
      case (rd_addr)
         `CIBR_OFS_IDENTITY:
         begin
            sel_word[`CIBR_ID_MSB:`CIBR_ID_LSB]   = `CIBR_CHIP_ID;
            sel_word[`CIBR_REV_MSB:`CIBR_REV_LSB] = `CIBR_CHIP_REV;
         end
         `CIBR_OFS_BYTE_ORDER:
         begin
            // in reset the pattern is replaced so pollers can tell
            sel_word = rst_sync_q ? `CIBR_RESET_PATTERN : `CIBR_BYTE_PATTERN;
         end
         `CIBR_OFS_CONFIG:
         begin
            // only ready is populated, other bits stay zero
            sel_word[`CIBR_READY_BIT] = ready_q;
         end
         default:
         begin
            // unmapped: zero data, no hit
            sel_hit = 1'b0;
         end
      endcase
   end

   assign rd_bus.word  = sel_word;
   assign rd_bus.lanes = rd_lanes;

   // lane steering for partial reads
   cibr_lane_steer u_steer
   (
      .rd (rd_bus)
   );

   // every read is answered next cycle, in any device state
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rd_data_q <= 32'h00000000;
         rd_ack_q  <= 1'b0;
         rd_hit_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         rd_ack_q <= rd_req;
         if (rd_req)
         begin
            rd_data_q <= rd_bus.steered;
            rd_hit_q  <= sel_hit;
         end
      end
   end

   // writes are acknowledged and discarded; all fields are read-only
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wr_ack_q <= 1'b0;
      end
      else if (clk_en)
      begin
         wr_ack_q <= wr_req;
      end
   end

   assign rd_data       = rd_data_q;
   assign rd_ack        = rd_ack_q;
   assign rd_hit        = rd_hit_q;
   assign wr_ack        = wr_ack_q;
   assign dev_ready     = ready_q;
   assign pm_ready_bit  = ready_q;
   assign ready_int_set = int_pulse_q;

endmodule

// *** testbench/cibr_status_regs_properties.sv ***
/*
 holds the port checks of the status register bank.
 assumes a bind onto cibr_status_regs, the checked pins by name.
*/
`timescale 1ns/1ns
`include "cibr_defines.svh"

module cibr_status_regs_chk
(
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic        clk_en,
   input wire logic        dev_reset_pin,
   input wire logic        rd_req,
   input wire logic [11:0] rd_addr,
   input wire logic [3:0]  rd_lanes,
   input wire logic        wr_req,
   input wire logic [31:0] rd_data,
   input wire logic        rd_ack,
   input wire logic        wr_ack,
   input wire logic        dev_ready,
   input wire logic        pm_ready_bit,
   input wire logic        ready_int_set
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   chk_read_answer_due: assert property (clk_en && rd_req |=> rd_ack)
      else $error("read not answered");
   chk_ack_has_cause: assert property (rd_ack |-> $past(rd_req))
      else $error("stray read answer");
   chk_identity_word: assert property (rd_ack && $past(rd_addr) == 12'h050
      && $past(rd_lanes) == 4'hf |-> rd_data == {`CIBR_CHIP_ID, `CIBR_CHIP_REV})
      else $error("identity word wrong");
   chk_pattern_word: assert property (rd_ack && $past(rd_addr) == 12'h064
      && $past(rd_lanes) == 4'hf |-> rd_data inside {32'h87654321, `CIBR_RESET_PATTERN})
      else $error("byte order word wrong");
   chk_config_word: assert property (rd_ack && $past(rd_addr) == 12'h074 && $past(rd_lanes[3])
      |-> rd_data == {4'h0, $past(dev_ready), 27'h0})
      else $error("configuration word wrong");
   chk_ready_mirror: assert property (pm_ready_bit == dev_ready)
      else $error("power control copy differs");
   chk_ready_int_pulse: assert property ($rose(dev_ready) |-> ##1 ready_int_set ##1 !ready_int_set)
      else $error("ready pulse missing");
   chk_int_has_cause: assert property (ready_int_set |-> $past(dev_ready) && !$past(dev_ready, 2))
      else $error("ready pulse without edge");
   chk_ready_in_reset: assert property (dev_reset_pin [*5] |-> !dev_ready)
      else $error("ready high in reset");
   chk_write_answer: assert property (clk_en && wr_req |=> wr_ack)
      else $error("write not answered");

   // main scenarios seen
   cov_ready_rise: cover property ($rose(dev_ready));
   cov_back_to_back: cover property (rd_req [*2]);
   cov_part_read: cover property (rd_req && rd_lanes != 4'hf);
endmodule

bind cibr_status_regs cibr_status_regs_chk chk_u
(
   .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .dev_reset_pin(dev_reset_pin),
   .rd_req(rd_req), .rd_addr(rd_addr), .rd_lanes(rd_lanes), .wr_req(wr_req),
   .rd_data(rd_data), .rd_ack(rd_ack), .wr_ack(wr_ack), .dev_ready(dev_ready),
   .pm_ready_bit(pm_ready_bit), .ready_int_set(ready_int_set)
);

// *** testbench/cibr_host_model.sv ***
/*
 holds the local host that reads and writes the bank.
 assumes the caller enters each task just after a rising edge.
*/
`timescale 1ns/1ns

module cibr_host_model
(
   input  wire logic sys_clk,
   output logic        rd_req,
   output logic [11:0] rd_addr,
   output logic [3:0]  rd_lanes,
   output logic        wr_req,
   output logic [11:0] wr_addr,
   output logic [31:0] wr_data
);
   initial
   begin
      rd_req = 1'b0;
      wr_req = 1'b0;
      rd_addr = 12'h000;
      rd_lanes = 4'h0;
      wr_addr = 12'h000;
      wr_data = 32'h0;
   end

   // one read strobe; caller only reads safe places before ready, spacer reads allowed
   task automatic read(input logic [11:0] a, input logic [3:0] l);
      // a read right after a write must drop the write strobe
      wr_req <= 1'b0;
      rd_req <= 1'b1;
      rd_addr <= a;
      rd_lanes <= l;
      @(posedge sys_clk);
   endtask

   // one write strobe, issued only once ready was seen
   task automatic write(input logic [11:0] a, input logic [31:0] d);
      // a write right after a read must drop the read strobe
      rd_req <= 1'b0;
      wr_req <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge sys_clk);
   endtask

   // strobes drop; rd_addr and wr_data show the inverse of their last value
   task automatic idle();
      rd_req <= 1'b0;
      wr_req <= 1'b0;
      rd_addr <= ~rd_addr;
      wr_data <= ~wr_data;
      @(posedge sys_clk);
   endtask
endmodule

// *** testbench/chip_id_bytetest_ready_regs_tb.sv ***
/*
 holds the self-checking bench of the status register bank.
 assumes the design, its defines header and the host model are compiled.
*/
`timescale 1ns/1ns
`include "cibr_defines.svh"

module chip_id_bytetest_ready_regs_tb;
   logic                 sys_clk, srst, clk_en, dev_reset_pin, power_saving, stable_pin;
   logic                 rd_req, wr_req, rd_ack, rd_hit, wr_ack;
   logic                 dev_ready, pm_ready_bit, ready_int_set;
   logic [11:0]          rd_addr, wr_addr;
   logic [3:0]           rd_lanes;
   logic [31:0]          wr_data;
   cibr_pkg::cibr_word_type rd_data;
   logic [32:0]          notes[$];  // expected {hit, data} in issue order
   logic [31:0]          seed = 32'hb5ab;
   logic [11:0]          places[5] = '{12'h050, 12'h064, 12'h074, 12'h060, 12'h070};
   logic                 in_rst, rdy;
   int                   err_total, comparisons, ints;

   cibr_status_regs dut_u
   (
      .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .dev_reset_pin(dev_reset_pin),
      .power_saving(power_saving), .stable_pin(stable_pin), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_lanes(rd_lanes), .wr_req(wr_req), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_data(rd_data), .rd_ack(rd_ack), .rd_hit(rd_hit),
      .wr_ack(wr_ack), .dev_ready(dev_ready), .pm_ready_bit(pm_ready_bit),
      .ready_int_set(ready_int_set)
   );
   cibr_host_model host_u (.sys_clk(sys_clk), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_lanes(rd_lanes), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (err_total == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // note the expected answer, then let the host issue the read
   task automatic rd(input logic [11:0] a, input logic [3:0] l);
      logic [31:0] w;
      w = (a == 12'h050) ? {`CIBR_CHIP_ID, `CIBR_CHIP_REV} :
          (a == 12'h064) ? (in_rst ? 32'hffffffff : 32'h87654321) :
          (a == 12'h074) ? {4'h0, rdy, 27'h0} : 32'h0;
      w &= {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
      notes.push_back({(a inside {12'h050, 12'h064, 12'h074}), w});
      host_u.read(a, l);
   endtask

   // clock at 4 ns
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // answers are compared against the oldest note
   always @(posedge sys_clk)
   begin
      if (rd_ack === 1'b1)
         check({rd_hit, rd_data}, notes.pop_front());
      if (ready_int_set === 1'b1)
         ints++;
   end

   // watchdog
   initial
   begin
      repeat (3000) @(posedge sys_clk);
      err_total++;
      tally_and_finish();
   end

   // main sequence
   initial
   begin
      {srst, clk_en, dev_reset_pin, stable_pin, in_rst} = 5'h1f;
      {power_saving, rdy} = 2'b00;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      rd(12'h064, 4'hf);
      rd(12'h074, 4'hf);
      rd(12'h064, 4'h6);
      host_u.idle();
      dev_reset_pin <= 1'b0;
      repeat (4) host_u.idle();
      in_rst = 1'b0;
      rd(12'h064, 4'hf);
      repeat (40) host_u.idle();
      rdy = 1'b1;
      check({32'h0, dev_ready}, 33'h1);
      for (int i = 0; i < 24; i++)
      begin
         host_u.write(12'h050, rnd());
         rd(places[i % 5], 4'(rnd() >> 7));
      end
      host_u.idle();
      power_saving <= 1'b1;
      repeat (6) host_u.idle();
      rdy = 1'b0;
      rd(12'h074, 4'hf);
      power_saving <= 1'b0;
      repeat (40) host_u.idle();
      rdy = 1'b1;
      rd(12'h074, 4'h8);
      host_u.idle();
      // freeze the bank while stable drops: ready must hold until enabled again
      clk_en <= 1'b0;
      stable_pin <= 1'b0;
      repeat (4) host_u.idle();
      check({32'h0, dev_ready}, 33'h1);
      clk_en <= 1'b1;
      repeat (4) host_u.idle();
      rdy = 1'b0;
      rd(12'h074, 4'hf);
      repeat (3) host_u.idle();
      check(33'(ints), 33'h2);
      check(33'(notes.size()), 33'h0);
      tally_and_finish();
   end
endmodule
